// *** hdl/bcs_pkg.sv ***
package bcs_pkg;
    localparam int PC_W = 16;
    localparam int PAGE_W = 11;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam int STATES_PER_CYCLE = 6;
    localparam logic [2:0] STATE_LAST = 3'h5;
    localparam logic [2:0] STATE_S1 = 3'h0;
    localparam logic [2:0] STATE_S4 = 3'h3;
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_LONG_JUMP = 8'h02;
    localparam logic [7:0] OP_LONG_CALL = 8'h12;
    localparam logic [7:0] OP_SUB_RETURN = 8'h22;
    localparam logic [7:0] OP_INT_RETURN = 8'h32;
    localparam logic [7:0] OP_BR_ACC_ZERO = 8'h60;
    localparam logic [7:0] OP_BR_ACC_NZ = 8'h70;
    localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
    localparam logic [7:0] OP_JMP_IDX = 8'h73;
    localparam logic [7:0] OP_CMP_ACC_IMM = 8'hB4;
    localparam logic [7:0] OP_CMP_ACC_DIR = 8'hB5;
    localparam logic [7:0] OP_DEC_BR_DIR = 8'hD5;
    localparam logic [4:0] PAGE_JMP_LOW = 5'h01;
    localparam logic [4:0] PAGE_CALL_LOW = 5'h11;
    localparam logic [4:0] CMP_IND_HI = 5'h16;
    localparam logic [4:0] CMP_REG_HI = 5'h17;
    localparam logic [4:0] DEC_BR_REG_HI = 5'h1B;
    localparam logic [3:0] EXT_MOVE_HI = 4'hE;
    localparam logic [3:0] EXT_MOVE_HI2 = 4'hF;
    typedef enum {ST_IDLE_UNUSED} bcs_dummy_t;
    typedef enum {EX_FETCH, EX_OPND1, EX_OPND2, EX_EXEC, EX_EXTMOVE} bcs_exec_t;
endpackage : bcs_pkg

// *** hdl/bcs_timing.sv ***
`timescale 1ns/1ps
`default_nettype none
// Machine-cycle state and phase generator
module bcs_timing
    import bcs_pkg::*;
(
    input wire logic clk_i,       // Oscillator clock
    input wire logic rst_b_i,     // Async reset, low
    output logic [2:0] state_o,   // 0..5 means S1..S6
    output logic phase2_o,        // High in second half
    output logic cycle_end_o      // End of S6 phase 2
);
    logic [2:0] state_reg;
    logic phase_reg;

    // Two oscillator periods per state, six states per cycle
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_reg <= STATE_S1;
            phase_reg <= 1'b0;
        end
        else
        begin
            phase_reg <= ~phase_reg;
            if (phase_reg)
                state_reg <= (state_reg == STATE_LAST) ? STATE_S1 : state_reg + 3'h1;
        end
    end

    assign state_o = state_reg;
    assign phase2_o = phase_reg;
    assign cycle_end_o = phase_reg && (state_reg == STATE_LAST);
endmodule : bcs_timing
`default_nettype wire

// *** hdl/bcs_branch.sv ***
`timescale 1ns/1ps
`default_nettype none
// Branch condition and relative target arithmetic
module bcs_branch
    import bcs_pkg::*;
(
    input wire logic [15:0] pc_next_i,  // Address after instruction
    input wire logic [7:0] rel_i,       // Signed offset byte
    input wire logic [7:0] opa_i,       // First compare operand
    input wire logic [7:0] opb_i,       // Second compare operand
    input wire logic [7:0] acc_i,       // Accumulator value
    output logic [15:0] rel_target_o,   // Relative destination
    output logic acc_zero_o,            // Accumulator is zero
    output logic differ_o,              // Operands differ
    output logic less_o,                // Unsigned opa < opb
    output logic [7:0] dec_o,           // Decremented opa
    output logic dec_nz_o               // Decrement result nonzero
);
    // Sign extend so -128..+127 from the next instruction
    assign rel_target_o = pc_next_i + {{8{rel_i[7]}}, rel_i};
    assign acc_zero_o = (acc_i == 8'h00);
    assign differ_o = (opa_i != opb_i);
    assign less_o = (opa_i < opb_i);
    assign dec_o = opa_i - 8'h01;
    assign dec_nz_o = (dec_o != 8'h00);
endmodule : bcs_branch
`default_nettype wire

// *** hdl/bcs_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
// Program-flow sequencer: fetch schedule plus jump, call, return
module bcs_sequencer
    import bcs_pkg::*;
(
    input wire logic MCLK_I,              // Oscillator clock
    input wire logic RST_B_I,             // Async reset, low
    input wire logic [7:0] CODE_I,        // Code byte from memory
    input wire logic [7:0] ACC_I,         // Accumulator contents
    input wire logic [15:0] DATA_PTR_I,   // Data pointer register
    input wire logic [7:0] OPND_I,        // Direct/indirect/register byte
    input wire logic [15:0] STACK_PC_I,   // Return address popped
    input wire logic INT_ACTIVE_I,        // Interrupt in progress
    output logic [15:0] PC_O,             // Program counter
    output logic FETCH_O,                 // Code fetch strobe
    output logic [15:0] PUSH_PC_O,        // Return address to push
    output logic PUSH_O,                  // Push strobe
    output logic POP_O,                   // Pop strobe
    output logic INT_DONE_O,              // Interrupt finished pulse
    output logic [7:0] OPND_WR_O,         // Decremented operand
    output logic OPND_WE_O,               // Operand write strobe
    output logic CARRY_O,                 // Carry flag value
    output logic CARRY_WE_O,              // Carry write strobe
    output logic [2:0] STATE_O,           // Machine state S1..S6
    output logic PHASE2_O                 // Phase two indicator
);
    logic [2:0] state;
    logic phase2;
    logic cycle_end;
    logic [15:0] pc_reg, pc_next;
    logic [7:0] ir_reg, b1_reg, b2_reg;
    logic [1:0] need_reg, got_reg;
    logic ext_second_reg;
    logic [15:0] rel_target;
    logic acc_zero, differ, less, dec_nz;
    logic [7:0] dec_val;
    logic [7:0] cmp_a, cmp_b, rel_byte;
    logic fetch_slot;
    logic fetch_reg, push_reg, pop_reg, int_done_reg, opnd_we_reg, carry_reg, carry_we_reg;
    logic [15:0] push_pc_reg;
    logic [7:0] opnd_wr_reg;
    logic [2:0] state_out_reg;
    logic phase2_out_reg;

    // Compare forms on an indirect or register byte; B0..B3 are other opcodes
    function automatic logic is_cmp_ind(input logic [7:0] op);
        return op[7:3] == CMP_REG_HI || (op[7:3] == CMP_IND_HI && op[2:1] == 2'b11);
    endfunction : is_cmp_ind

    // Any compare-and-branch form
    function automatic logic is_cmp_br(input logic [7:0] op);
        return op == OP_CMP_ACC_IMM || op == OP_CMP_ACC_DIR || is_cmp_ind(op);
    endfunction : is_cmp_br

    // Any decrement-and-branch form
    function automatic logic is_dec_br(input logic [7:0] op);
        return op == OP_DEC_BR_DIR || op[7:3] == DEC_BR_REG_HI;
    endfunction : is_dec_br

    // Operand bytes each instruction needs after the opcode
    function automatic logic [1:0] bytes_needed(input logic [7:0] op);
        logic [1:0] n;
        n = 2'd0;
        if (op == OP_LONG_JUMP || op == OP_LONG_CALL || is_cmp_br(op) || op == OP_DEC_BR_DIR)
            n = 2'd2;
        else if (op[4:0] == PAGE_JMP_LOW || op[4:0] == PAGE_CALL_LOW || op == OP_SHORT_JUMP
                 || op == OP_BR_ACC_ZERO || op == OP_BR_ACC_NZ || op[7:3] == DEC_BR_REG_HI)
            n = 2'd1;
        return n;
    endfunction : bytes_needed

    // External data move opcodes, both widths and directions
    function automatic logic is_ext_move(input logic [7:0] op);
        return (op[7:4] == EXT_MOVE_HI || op[7:4] == EXT_MOVE_HI2) && (op[3:0] == 4'h0 || op[3:1] == 3'h1);
    endfunction : is_ext_move

    bcs_timing u_timing (
        .clk_i(MCLK_I),
        .rst_b_i(RST_B_I),
        .state_o(state),
        .phase2_o(phase2),
        .cycle_end_o(cycle_end)
    );

    // Compare operands and relative byte selection per form
    always_comb
    begin
        cmp_a = ACC_I;
        cmp_b = b1_reg;
        rel_byte = b1_reg;
        if (is_cmp_br(ir_reg))
        begin
            rel_byte = b2_reg;
            if (ir_reg == OP_CMP_ACC_DIR)
                cmp_b = OPND_I;
            else if (is_cmp_ind(ir_reg))
            begin
                cmp_a = OPND_I;
                cmp_b = b1_reg;
            end
        end
        else if (ir_reg == OP_DEC_BR_DIR)
        begin
            cmp_a = OPND_I;
            rel_byte = b2_reg;
        end
        else if (ir_reg[7:3] == DEC_BR_REG_HI)
            cmp_a = OPND_I;
    end

    bcs_branch u_branch (
        .pc_next_i(pc_reg),
        .rel_i(rel_byte),
        .opa_i(cmp_a),
        .opb_i(cmp_b),
        .acc_i(ACC_I),
        .rel_target_o(rel_target),
        .acc_zero_o(acc_zero),
        .differ_o(differ),
        .less_o(less),
        .dec_o(dec_val),
        .dec_nz_o(dec_nz)
    );

    // Fetches fall in S1 and S4, phase one
    assign fetch_slot = !phase2 && (state == STATE_S1 || state == STATE_S4) && !ext_second_reg;

    // Next PC once the instruction is fully fetched
    always_comb
    begin
        pc_next = pc_reg;
        if (ir_reg == OP_LONG_JUMP || ir_reg == OP_LONG_CALL)
            pc_next = {b1_reg, b2_reg};
        else if (ir_reg[4:0] == PAGE_JMP_LOW || ir_reg[4:0] == PAGE_CALL_LOW)
            pc_next = {pc_reg[15:11], ir_reg[7:5], b1_reg};
        else if (ir_reg == OP_JMP_IDX)
            pc_next = DATA_PTR_I + {8'h00, ACC_I};
        else if (ir_reg == OP_SUB_RETURN || ir_reg == OP_INT_RETURN)
            pc_next = STACK_PC_I;
        else if (ir_reg == OP_SHORT_JUMP)
            pc_next = rel_target;
        else if ((ir_reg == OP_BR_ACC_ZERO && acc_zero) || (ir_reg == OP_BR_ACC_NZ && !acc_zero))
            pc_next = rel_target;
        else if (is_dec_br(ir_reg) && dec_nz)
            pc_next = rel_target;
        else if (is_cmp_br(ir_reg) && differ)
            pc_next = rel_target;
    end

    // Opcode and operand capture, PC advance only for used bytes
    always_ff @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            pc_reg <= PC_RESET;
            ir_reg <= OP_NOP;
            b1_reg <= 8'h00;
            b2_reg <= 8'h00;
            need_reg <= 2'd0;
            got_reg <= 2'd0;
            ext_second_reg <= 1'b0;
        end
        else
        begin
            if (fetch_slot)
            begin
                if (state == STATE_S1 && got_reg == need_reg)
                begin
                    ir_reg <= CODE_I;
                    need_reg <= bytes_needed(CODE_I);
                    got_reg <= 2'd0;
                    pc_reg <= pc_reg + 16'h0001;
                end
                else if (got_reg != need_reg)
                begin
                    if (got_reg == 2'd0)
                        b1_reg <= CODE_I;
                    else
                        b2_reg <= CODE_I;
                    got_reg <= got_reg + 2'd1;
                    pc_reg <= pc_reg + 16'h0001;
                end
                // Otherwise the extra byte is ignored, PC held
            end
            if (cycle_end)
            begin
                // Execute at end of S6 once all bytes are present
                if (ext_second_reg)
                    ext_second_reg <= 1'b0;
                else if (is_ext_move(ir_reg) && got_reg == need_reg)
                    ext_second_reg <= 1'b1;
                if (got_reg == need_reg && !ext_second_reg)
                begin
                    pc_reg <= pc_next;
                    ir_reg <= OP_NOP;
                    need_reg <= 2'd0;
                    got_reg <= 2'd0; // Stale count would swallow the next opcode
                end
            end
        end
    end

    // Side effects issued with execution
    always_ff @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            push_reg <= 1'b0;
            push_pc_reg <= PC_RESET;
            pop_reg <= 1'b0;
            int_done_reg <= 1'b0;
            opnd_we_reg <= 1'b0;
            opnd_wr_reg <= 8'h00;
            carry_reg <= 1'b0;
            carry_we_reg <= 1'b0;
        end
        else
        begin
            push_reg <= 1'b0;
            pop_reg <= 1'b0;
            int_done_reg <= 1'b0;
            opnd_we_reg <= 1'b0;
            carry_we_reg <= 1'b0;
            if (cycle_end && got_reg == need_reg && !ext_second_reg)
            begin
                if (ir_reg == OP_LONG_CALL || ir_reg[4:0] == PAGE_CALL_LOW)
                begin
                    push_reg <= 1'b1;
                    push_pc_reg <= pc_reg;
                end
                if (ir_reg == OP_SUB_RETURN || ir_reg == OP_INT_RETURN)
                    pop_reg <= 1'b1;
                if (ir_reg == OP_INT_RETURN && INT_ACTIVE_I)
                    int_done_reg <= 1'b1;
                if (is_dec_br(ir_reg))
                begin
                    opnd_we_reg <= 1'b1;
                    opnd_wr_reg <= dec_val;
                end
                if (is_cmp_br(ir_reg))
                begin
                    carry_we_reg <= 1'b1;
                    carry_reg <= less;
                end
            end
        end
    end

    // Registered copies of timing and fetch for the ports
    always_ff @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            fetch_reg <= 1'b0;
            state_out_reg <= STATE_S1;
            phase2_out_reg <= 1'b0;
        end
        else
        begin
            fetch_reg <= fetch_slot;
            state_out_reg <= state;
            phase2_out_reg <= phase2;
        end
    end

    assign PC_O = pc_reg;
    assign FETCH_O = fetch_reg;
    assign PUSH_O = push_reg;
    assign PUSH_PC_O = push_pc_reg;
    assign POP_O = pop_reg;
    assign INT_DONE_O = int_done_reg;
    assign OPND_WE_O = opnd_we_reg;
    assign OPND_WR_O = opnd_wr_reg;
    assign CARRY_O = carry_reg;
    assign CARRY_WE_O = carry_we_reg;
    assign STATE_O = state_out_reg;
    assign PHASE2_O = phase2_out_reg;
endmodule : bcs_sequencer
`default_nettype wire

// *** bench/bcs_sequencer_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// Port-level timing and strobe relations of the sequencer
module bcs_seq_chk
    import bcs_pkg::*;
(
    input wire logic MCLK_I, // Clock
    input wire logic RST_B_I, // Reset, low
    input wire logic [7:0] OPND_I, // Operand byte
    input wire logic [15:0] STACK_PC_I, // Stack top
    input wire logic INT_ACTIVE_I, // Interrupt busy
    input wire logic [15:0] PC_O, // Program counter
    input wire logic FETCH_O, // Fetch slot
    input wire logic [15:0] PUSH_PC_O, // Pushed address
    input wire logic PUSH_O, // Push strobe
    input wire logic POP_O, // Pop strobe
    input wire logic INT_DONE_O, // Interrupt done
    input wire logic [7:0] OPND_WR_O, // Written operand
    input wire logic OPND_WE_O, // Operand strobe
    input wire logic [2:0] STATE_O, // Machine state
    input wire logic PHASE2_O // Phase two
);
    logic [1:0] warm_reg;
    // Registered state copies lag the release, so skip the first edges
    always_ff @(posedge MCLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            warm_reg <= 2'h0;
        else if (warm_reg != 2'h3)
            warm_reg <= warm_reg + 2'h1;
    end
    default clocking @(posedge MCLK_I);
    endclocking
    default disable iff (!RST_B_I || warm_reg != 2'h3);
    // First half of S1
    sequence s_first;
        STATE_O == STATE_S1 && !PHASE2_O;
    endsequence
    state_wrap_a: assert property (STATE_O == STATE_LAST && PHASE2_O |=> s_first)
        else $error("state does not wrap to S1");
    state_step_a: assert property (PHASE2_O && STATE_O != STATE_LAST |=> STATE_O == $past(STATE_O) + 3'h1)
        else $error("state does not advance");
    state_hold_a: assert property (!PHASE2_O |=> PHASE2_O && $stable(STATE_O))
        else $error("state half missing");
    phase_alt_a: assert property (PHASE2_O |=> !PHASE2_O)
        else $error("phase two too long");
    fetch_gap_a: assert property (FETCH_O |=> !FETCH_O [*5])
        else $error("fetch slots too close");
    push_addr_a: assert property (PUSH_O |-> PUSH_PC_O == $past(PC_O) ##1 !PUSH_O)
        else $error("pushed address wrong");
    pop_target_a: assert property (POP_O |-> PC_O == $past(STACK_PC_I) ##1 !POP_O)
        else $error("return target wrong");
    int_done_a: assert property (INT_DONE_O |-> POP_O && $past(INT_ACTIVE_I))
        else $error("interrupt done without return");
    dec_write_a: assert property (OPND_WE_O |-> OPND_WR_O == $past(OPND_I) - 8'h01)
        else $error("decrement value wrong");
endmodule : bcs_seq_chk
bind bcs_sequencer bcs_seq_chk u_bcs_seq_chk (
    .MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .OPND_I(OPND_I), .STACK_PC_I(STACK_PC_I), .INT_ACTIVE_I(INT_ACTIVE_I),
    .PC_O(PC_O), .FETCH_O(FETCH_O), .PUSH_PC_O(PUSH_PC_O), .PUSH_O(PUSH_O), .POP_O(POP_O),
    .INT_DONE_O(INT_DONE_O), .OPND_WR_O(OPND_WR_O), .OPND_WE_O(OPND_WE_O), .STATE_O(STATE_O), .PHASE2_O(PHASE2_O)
);
`default_nettype wire

// *** bench/bcs_code_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
// Code memory, return stack and interrupt state beside the sequencer
module bcs_code_mem (
    input wire logic clk_i, // Clock
    input wire logic rst_b_i, // Reset, low
    input wire logic [15:0] pc_i, // Fetch address
    input wire logic push_i, // Push strobe
    input wire logic [15:0] push_pc_i, // Address to push
    input wire logic pop_i, // Pop strobe
    input wire logic int_done_i, // Interrupt finished
    input wire logic int_set_i, // Start an interrupt
    output logic [7:0] code_o, // Byte at pc_i
    output logic [15:0] stack_pc_o, // Stack top
    output logic int_active_o // Interrupt busy
);
    logic [7:0] mem [0:65535];
    logic [15:0] stk [0:7];
    int sp;
    // Memory is always enabled, so the byte follows the address
    assign code_o = mem[pc_i];
    // Empty stack gives a pattern, never a stale address
    assign stack_pc_o = (sp > 0) ? stk[sp - 1] : 16'hA5A5;
    // Stack moves on strobes sampled at the edge
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            sp <= 0;
        else if (push_i)
        begin
            stk[sp] <= push_pc_i;
            sp <= sp + 1;
        end
        else if (pop_i && sp > 0)
            sp <= sp - 1;
    end
    // Interrupt stays in progress until the done pulse
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            int_active_o <= 1'b0;
        else if (int_done_i)
            int_active_o <= 1'b0;
        else if (int_set_i)
            int_active_o <= 1'b1;
    end
endmodule : bcs_code_mem
`default_nettype wire

// *** bench/tb_branch_and_cycle_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("CHECK FAILED %s exp=%h got=%h", what, exp, got); \
        end \
    end
module tb_branch_and_cycle_sequencer
    import bcs_pkg::*;
();
    logic mclk = 1'b0, rst_b = 1'b0, int_set = 1'b0;
    logic [7:0] acc = 8'h00, opnd = 8'h00, code, opnd_wr;
    logic [15:0] data_ptr = 16'h0000, prev_pc = 16'h0000, stack_pc, pc, push_pc;
    logic int_active, fetch, push, pop, int_done, opnd_we, carry, carry_we, phase2;
    logic [2:0] state;
    logic [19:0] exp_q[$];
    logic [31:0] r;
    int bad_count = 0, n_compared = 0, cyc = 0, j_last = 0, j_gap = 0;
    // Oscillator, 10 ns period
    always #5 mclk = ~mclk;
    bcs_sequencer u_bcs_sequencer (
        .MCLK_I(mclk), .RST_B_I(rst_b), .CODE_I(code), .ACC_I(acc), .DATA_PTR_I(data_ptr), .OPND_I(opnd),
        .STACK_PC_I(stack_pc), .INT_ACTIVE_I(int_active), .PC_O(pc), .FETCH_O(fetch), .PUSH_PC_O(push_pc),
        .PUSH_O(push), .POP_O(pop), .INT_DONE_O(int_done), .OPND_WR_O(opnd_wr), .OPND_WE_O(opnd_we),
        .CARRY_O(carry), .CARRY_WE_O(carry_we), .STATE_O(state), .PHASE2_O(phase2)
    );
    bcs_code_mem u_bcs_code_mem (
        .clk_i(mclk), .rst_b_i(rst_b), .pc_i(pc), .push_i(push), .push_pc_i(push_pc), .pop_i(pop),
        .int_done_i(int_done), .int_set_i(int_set), .code_o(code), .stack_pc_o(stack_pc), .int_active_o(int_active)
    );
    task summarize;
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize
    // Event code: kind nibble 1 jump, 2 push, 3 pop, 4 int done, 5 operand write, 6 carry
    task ex(input logic [3:0] k, input logic [15:0] v);
        exp_q.push_back({k, v});
    endtask : ex
    task seen(input logic [19:0] ev);
        logic [19:0] e;
        e = (exp_q.size() != 0) ? exp_q.pop_front() : 20'hFFFFF;
        `CHK("event", e, ev)
    endtask : seen
    task ld(input logic [15:0] a, input logic [23:0] v, input int n);
        for (int i = 0; i < n; i++)
            u_bcs_code_mem.mem[a + i] = v[8 * (n - 1 - i) +: 8];
    endtask : ld
    // Bounded wait until every noted event has shown up
    task drain;
        int k;
        k = 0;
        while (exp_q.size() != 0 && k < 600)
        begin
            @(posedge mclk);
            k++;
        end
        if (exp_q.size() != 0)
        begin
            bad_count++;
            summarize();
        end
        #1;
    endtask : drain
    // Sample mid-cycle; a jump is any step of the counter other than +1
    always @(negedge mclk)
    begin
        cyc++;
        if (rst_b === 1'b1)
        begin
            if (pc !== prev_pc && pc !== prev_pc + 16'h0001)
            begin
                seen({4'h1, pc});
                j_gap = cyc - j_last;
                j_last = cyc;
            end
            if (push === 1'b1) seen({4'h2, push_pc});
            if (pop === 1'b1) seen({4'h3, 16'h0000});
            if (int_done === 1'b1) seen({4'h4, 16'h0000});
            if (opnd_we === 1'b1) seen({4'h5, 8'h00, opnd_wr});
            if (carry_we === 1'b1) seen({4'h6, 15'h0000, carry});
        end
        prev_pc = pc;
    end
    // Whole program is loaded up front; operands change only after the previous event
    initial
    begin
        void'($urandom(42293));
        for (int i = 0; i < 65536; i++) u_bcs_code_mem.mem[i] = OP_NOP;
        ld(16'h0000, {OP_LONG_JUMP, 16'h1234}, 3);
        ld(16'h1234, {OP_BR_ACC_ZERO, 8'h10}, 2);
        ld(16'h1246, {OP_BR_ACC_ZERO, 8'h20}, 2);
        ld(16'h1248, {OP_BR_ACC_NZ, 8'h80}, 2);
        ld(16'h11CA, {16'h0000, OP_JMP_IDX}, 1);
        ld(16'h0008, {OP_DEC_BR_DIR, 8'h30, 8'h05}, 3);
        ld(16'h000B, {DEC_BR_REG_HI, 3'h0, 8'h7F}, 2);
        ld(16'h000D, {OP_SHORT_JUMP, 8'h7F}, 2);
        ld(16'h008E, {DEC_BR_REG_HI, 3'h0, 8'h10}, 2);
        ld(16'h00A0, {OP_CMP_ACC_IMM, 8'h40, 8'h10}, 3);
        ld(16'h00A3, {OP_CMP_ACC_IMM, 8'h41, 8'h08}, 3);
        ld(16'h00AE, {OP_CMP_ACC_DIR, 8'h30, 8'h10}, 3);
        ld(16'h00C1, {CMP_IND_HI, 3'h6, 8'h7F, 8'h05}, 3);
        ld(16'h00C9, {OP_LONG_CALL, 16'h7F00}, 3);
        ld(16'h7F00, {3'h1, PAGE_CALL_LOW, 8'hF5}, 2);
        ld(16'h79F5, {3'h7, PAGE_JMP_LOW, 8'hFF}, 2);
        ld(16'h7FFF, {16'h0000, OP_INT_RETURN}, 1);
        ld(16'h7F02, {16'h0000, OP_INT_RETURN}, 1);
        ld(16'h00CC, {16'h0000, EXT_MOVE_HI, 4'h0}, 1);
        ld(16'h00CD, {OP_LONG_JUMP, 16'h0100}, 3);
        ld(16'h0100, {16'h0000, OP_JMP_IDX}, 1);
        repeat (5) @(posedge mclk);
        `CHK("reset pc", 16'h0000, pc)
        #1 rst_b = 1'b1;
        ex(4'h1, 16'h1234);
        ex(4'h1, 16'h1246);
        drain();
        acc = 8'h05;
        ex(4'h1, 16'h11CA);
        drain();
        acc = 8'h10;
        data_ptr = 16'hFFF8;
        ex(4'h1, 16'h0008);
        drain();
        opnd = 8'h01;
        ex(4'h5, 16'h0000);
        ex(4'h5, 16'h0000);
        ex(4'h1, 16'h008E);
        drain();
        opnd = 8'h00;
        ex(4'h1, 16'h00A0);
        ex(4'h5, 16'h00FF);
        drain();
        acc = 8'h40;
        ex(4'h6, 16'h0000);
        ex(4'h1, 16'h00AE);
        ex(4'h6, 16'h0001);
        drain();
        acc = 8'h7F;
        opnd = 8'h80;
        ex(4'h1, 16'h00C1);
        ex(4'h6, 16'h0001);
        ex(4'h1, 16'h00C9);
        ex(4'h6, 16'h0000);
        ex(4'h1, 16'h7F00);
        ex(4'h2, 16'h00CC);
        ex(4'h1, 16'h79F5);
        ex(4'h2, 16'h7F02);
        ex(4'h1, 16'h7FFF);
        drain();
        int_set = 1'b1;
        @(posedge mclk);
        #1 int_set = 1'b0;
        ex(4'h1, 16'h7F02);
        ex(4'h3, 16'h0000);
        ex(4'h4, 16'h0000);
        ex(4'h1, 16'h00CC);
        ex(4'h3, 16'h0000);
        ex(4'h1, 16'h0100);
        drain();
        `CHK("ext move gap", 48, j_gap)
        r = $urandom;
        acc = r[23:16];
        data_ptr = {1'b1, r[14:0]};
        ex(4'h1, data_ptr + {8'h00, acc});
        drain();
        summarize();
    end
endmodule : tb_branch_and_cycle_sequencer
`default_nettype wire
